// [logic/fxu_pkg.sv]
// Package of the floating-point exception unit: register map, field
// positions, reset values, fault vectors and the carrier structs.
// Assumes one 20 MHz clock and a synchronous active-low reset.
// Summary of operation
// - Masked denormal operand: normalise it automatically
// - Transcendental and extract ops raise denormal too
// - Masked overflow, chop rounding: largest finite value
// - Unmasked overflow also sets precision flag
// - Unmasked overflow to stack: round at precision
// - Masked underflow only when tiny and losing accuracy
// - Unmasked underflow: adjust exponent, then round
// - Denormal priority same masked or unmasked
// - Saved pointer marks first prefix byte
// - Errors reach fault logic, no interrupt controller
// - Undefined opcode raises invalid-opcode fault, vector 6
// - Task-switched or emulation flag: vector 7 fault
// - Undefined opcode skips pending error check
// - Unmasked exception: error pin low at completion
// - Deferred mode: error before next op, held
// - Denormal sqrt/div/rem/convert: normalise, no invalid
// - Level-3 misaligned operand: alignment fault, stack exempt
// - Environment load: both end bytes before commit
package fxu_pkg;

	// Register byte addresses
	localparam logic [7:0] ADR_CTRL  = 8'h00; // Masks, precision, rounding, mode
	localparam logic [7:0] ADR_SYS   = 8'h04; // Main control register flags
	localparam logic [7:0] ADR_STAT  = 8'h08; // Sticky events, write one to clear
	localparam logic [7:0] ADR_IMASK = 8'h0C; // Interrupt enables
	localparam logic [7:0] ADR_SAVIP = 8'h10; // Saved instruction pointer
	localparam logic [7:0] ADR_SAVCS = 8'h14; // Saved code selector
	localparam logic [7:0] ADR_ACT   = 8'h18; // Last result action

	// Control word fields
	localparam int CTL_PREC = 8;  // Precision control, two bits
	localparam int CTL_RND  = 10; // Rounding control, two bits
	localparam int CTL_DEFER = 12; // Deferred error reporting
	localparam logic [15:0] CTRL_RST = 16'h030F; // All masked, extended, nearest
	localparam logic [1:0]  RND_CHOP = 2'h3;
	localparam logic [1:0]  PREC_EXT = 2'h3;

	// Main control register bits
	localparam int SYS_TASKSW = 0;
	localparam int SYS_EMUL   = 1;
	localparam int SYS_ALIGN  = 2;
	localparam logic [2:0] SYS_RST = 3'h0;

	// Status bits; the low four are the arithmetic exception flags
	localparam int STAT_W  = 9;
	localparam int ST_DEN  = 0;
	localparam int ST_OVF  = 1;
	localparam int ST_UNF  = 2;
	localparam int ST_PRE  = 3;
	localparam int ST_BADOP = 4;
	localparam int ST_NODEV = 5;
	localparam int ST_ALIGN = 6;
	localparam int ST_SEGAB = 7;
	localparam int ST_MF   = 8;
	localparam logic [STAT_W-1:0] STAT_RST = 9'h000;

	// Fault vectors
	localparam logic [7:0] VEC_BADOP = 8'h06;
	localparam logic [7:0] VEC_NODEV = 8'h07;
	localparam logic [7:0] VEC_SEGAB = 8'h0B;
	localparam logic [7:0] VEC_FPERR = 8'h10;
	localparam logic [7:0] VEC_ALIGN = 8'h11;

	localparam logic [1:0] PRIV_USER = 2'h3;
	localparam int ENV_BYTES = 28; // Environment image length

	// Result selection codes
	localparam logic [1:0] SEL_PASS = 2'h0;
	localparam logic [1:0] SEL_INF  = 2'h1;
	localparam logic [1:0] SEL_MAXF = 2'h2;

	// Instruction offered for issue
	typedef struct packed {
		logic        is_fp;      // Floating-point opcode space
		logic        defined;    // Opcode is defined
		logic        env_load;   // environment_load_op
		logic        stack_area; // Stack part of save/restore
		logic        has_mem;    // Has a memory data operand
		logic [1:0]  cpl;        // Current privilege level
		logic [1:0]  size;       // 0 word,1 dword,2 qword,3 ext
		logic [31:0] addr;       // Operand linear address
		logic [15:0] cs;         // Code selector
		logic [31:0] prefix_ip;  // Address of first prefix byte
	} fxu_issue_t;

	// Raw outcome of a finished arithmetic instruction
	typedef struct packed {
		logic       denorm;      // A source was denormal
		logic       arith;       // Arithmetic incl. transcendental/extract
		logic       norm_first;  // sqrt, divide, remainder, int/bcd convert
		logic       ovf;         // Exponent overflow
		logic       tiny;        // Result tiny
		logic       loss;        // Denormalising loses accuracy
		logic       inexact;     // Rounded result inexact
		logic       sign;        // Result sign
		logic       stack_dest;  // Destination on register stack
		logic       prec_gov;    // Governed by precision control
		logic       prec_by_op;  // Opcode fixes precision
		logic [1:0] prec_op;     // Precision given by opcode
	} fxu_done_t;

	// Action handed to the datapath
	typedef struct packed {
		logic       normalize;   // Normalise denormal sources first
		logic [1:0] sel;         // Result selection
		logic       sign;        // Sign for selected constant
		logic       round_en;    // Round significand on stack store
		logic [1:0] round_prec;  // Precision for that rounding
		logic       adj_exp;     // Adjust exponent before rounding
		logic [1:0] top_exc;     // Highest unmasked flag
		logic       unmasked;    // Any unmasked flag raised
	} fxu_act_t;

	typedef enum logic [1:0] {
		ENV_IDLE,
		ENV_FIRST,
		ENV_LAST,
		ENV_COMMIT
	} fxu_env_t;

endpackage : fxu_pkg

// [logic/fxu_align.sv]
// Alignment checker for floating-point memory operands.
// Assumes operands are naturally aligned to their size, extended at 8.
`timescale 1ns/1ns
module fxu_align
	import fxu_pkg::*;
(
	input  wire logic       chk_en_i,   // Alignment checking enabled
	input  wire fxu_issue_t issue_i,    // Instruction being issued
	output logic            fault_o     // Alignment fault
);
	logic mis; // Low address bits off the size boundary

	// Misalignment by operand size
	always_comb begin
		unique case (issue_i.size)
			2'h0: mis = issue_i.addr[0];
			2'h1: mis = |issue_i.addr[1:0];
			default: mis = |issue_i.addr[2:0];
		endcase
	end

	// Only user level, and stack area of save/restore is exempt
	assign fault_o = chk_en_i && issue_i.has_mem && issue_i.cpl == PRIV_USER
		&& !issue_i.stack_area && mis;

endmodule : fxu_align

// [logic/fxu_prio.sv]
// Priority pick among raised arithmetic exception flags.
// Assumes flags and masks use the status bit layout of the package.
`timescale 1ns/1ns
module fxu_prio
	import fxu_pkg::*;
(
	input  wire logic [3:0] flags_i,    // Raised flags
	input  wire logic [3:0] mask_i,     // Mask bits, one masks
	output logic [1:0]      top_o,      // Highest unmasked flag
	output logic            any_o       // Any unmasked flag
);
	logic [3:0] live; // Unmasked raised flags

	assign live = flags_i & ~mask_i;
	assign any_o = |live;

	// Fixed order; denormal ranks first whatever its mask, so the mask
	// only gates, it never reorders
	always_comb begin
		if (live[ST_DEN]) begin
			top_o = 2'(ST_DEN);
		end else if (live[ST_OVF]) begin
			top_o = 2'(ST_OVF);
		end else if (live[ST_UNF]) begin
			top_o = 2'(ST_UNF);
		end else begin
			top_o = 2'(ST_PRE);
		end
	end

endmodule : fxu_prio

// [logic/fxu_top.sv]
// Floating-point exception unit: issue checks, result exception
// handling, error pin, saved pointer, environment load ordering and
// the register file. Assumes the core offers one instruction per
// issue pulse and one outcome per done pulse, all on clk_sys_i.
//
// Local design decisions: strobed register access and the address map.
`timescale 1ns/1ns
module fxu_top
	import fxu_pkg::*;
#(
	parameter int ENV_LEN = ENV_BYTES // Environment image bytes
) (
	input  wire logic        clk_sys_i,   // 20 MHz system clock
	input  wire logic        nrst_i,      // Synchronous reset, low
	input  wire logic [7:0]  reg_addr_i,  // Register byte address
	input  wire logic [31:0] reg_wdata_i, // Write data
	input  wire logic        reg_wr_i,    // Write strobe
	input  wire logic        reg_rd_i,    // Read strobe
	output logic [31:0]      reg_rdata_o, // Read data, one cycle later
	input  wire logic        issue_i,     // Issue pulse
	input  wire fxu_issue_t  issue_d_i,   // Issued instruction
	input  wire logic        done_i,      // Completion pulse
	input  wire fxu_done_t   done_d_i,    // Completion outcome
	input  wire logic        mem_ack_i,   // Environment byte read done
	input  wire logic        mem_fault_i, // That read faulted
	output logic             mem_req_o,   // Environment byte read
	output logic [31:0]      mem_addr_o,  // Byte address
	output logic             env_commit_o, // Load internal state
	output logic             fault_o,     // Fault to core, pulse
	output logic [7:0]       fault_vec_o, // Fault vector
	output logic             hold_o,      // Issue blocked
	output logic             act_v_o,     // Action valid, pulse
	output fxu_act_t         act_o,       // Action to datapath
	output logic             fp_error_out_n, // Error pin, low active
	output logic             irq_o        // Level interrupt
);

	// All state of the unit
	typedef struct packed {
		logic [15:0]       ctrl;     // Control word
		logic [2:0]        sys;      // Main control flags
		logic [STAT_W-1:0] stat;     // Sticky status
		logic [STAT_W-1:0] imask;    // Interrupt enables
		logic [31:0]       sav_ip;   // Saved instruction pointer
		logic [15:0]       sav_cs;   // Saved selector
		logic [31:0]       rdata;    // Read data
		logic              irq;      // Interrupt level
		logic              err_n;    // Error pin
		logic              flt;      // Fault pulse
		logic [7:0]        vec;      // Fault vector
		logic              act_v;    // Action pulse
		fxu_act_t          act;      // Last action
		fxu_env_t          env;      // Environment load phase
		logic [31:0]       env_base; // Environment base address
		logic              mem_req;  // Byte read request
		logic [31:0]       mem_addr; // Byte address
		logic              commit;   // Commit pulse
		logic              hold;     // Issue blocked
	} fxu_state_t;

	fxu_state_t s;       // Registered state
	fxu_state_t next_s;  // Next state

	logic       align_flt;  // Alignment fault of issued op
	logic [3:0] raise;      // Flags raised by this outcome
	logic [1:0] top_exc;    // Highest unmasked raised flag
	logic       any_unm;    // Any unmasked raised flag
	logic [3:0] xmask;      // Exception masks
	logic       pend_err;   // Unmasked flag still set in status

	// Return true when an address hits the given register
	function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
		return a == r;
	endfunction : hit

	assign xmask = s.ctrl[3:0];
	assign pend_err = |(s.stat[3:0] & ~xmask);

	fxu_align u_align (
		.chk_en_i (s.sys[SYS_ALIGN]),
		.issue_i  (issue_d_i),
		.fault_o  (align_flt)
	);

	fxu_prio u_prio (
		.flags_i (raise),
		.mask_i  (xmask),
		.top_o   (top_exc),
		.any_o   (any_unm)
	);

	// Flags raised by a finished instruction
	always_comb begin
		raise = 4'h0;
		// Denormal raised for every arithmetic op, extract included
		raise[ST_DEN] = done_d_i.denorm && done_d_i.arith;
		raise[ST_OVF] = done_d_i.ovf;
		// Masked underflow needs loss of accuracy too
		if (xmask[ST_UNF]) begin
			raise[ST_UNF] = done_d_i.tiny && done_d_i.loss;
		end else begin
			raise[ST_UNF] = done_d_i.tiny;
		end
		// Unmasked overflow always marks precision as well
		raise[ST_PRE] = done_d_i.inexact || (done_d_i.ovf && !xmask[ST_OVF]);
	end

	// Next state
	always_comb begin
		next_s = s;
		next_s.flt = 1'b0;
		next_s.act_v = 1'b0;
		next_s.commit = 1'b0;
		next_s.rdata = 32'h0000_0000;

		// Register writes; status clears are overridden below by sets
		if (reg_wr_i) begin
			if (hit(reg_addr_i, ADR_CTRL)) begin
				next_s.ctrl = reg_wdata_i[15:0];
			end
			if (hit(reg_addr_i, ADR_SYS)) begin
				next_s.sys = reg_wdata_i[2:0];
			end
			if (hit(reg_addr_i, ADR_STAT)) begin
				next_s.stat = s.stat & ~reg_wdata_i[STAT_W-1:0];
			end
			if (hit(reg_addr_i, ADR_IMASK)) begin
				next_s.imask = reg_wdata_i[STAT_W-1:0];
			end
		end

		// Register reads; unmapped addresses read zero
		if (reg_rd_i) begin
			if (hit(reg_addr_i, ADR_CTRL)) begin
				next_s.rdata = {16'h0000, s.ctrl};
			end else if (hit(reg_addr_i, ADR_SYS)) begin
				next_s.rdata = {29'h0000_0000, s.sys};
			end else if (hit(reg_addr_i, ADR_STAT)) begin
				next_s.rdata = {23'h00_0000, s.stat};
			end else if (hit(reg_addr_i, ADR_IMASK)) begin
				next_s.rdata = {23'h00_0000, s.imask};
			end else if (hit(reg_addr_i, ADR_SAVIP)) begin
				next_s.rdata = s.sav_ip;
			end else if (hit(reg_addr_i, ADR_SAVCS)) begin
				next_s.rdata = {16'h0000, s.sav_cs};
			end else if (hit(reg_addr_i, ADR_ACT)) begin
				next_s.rdata = {21'h00_0000, s.act};
			end
		end

		// Issue checks, in order of precedence; faults go straight to
		// the core, never through an interrupt controller
		if (issue_i && issue_d_i.is_fp && s.env == ENV_IDLE) begin
			next_s.flt = 1'b1;
			if (s.sys[SYS_TASKSW] || s.sys[SYS_EMUL]) begin
				// Defined or not, no device while either flag is set
				next_s.vec = VEC_NODEV;
				next_s.stat[ST_NODEV] = 1'b1;
			end else if (!issue_d_i.defined) begin
				// Pending errors are deliberately not looked at here
				next_s.vec = VEC_BADOP;
				next_s.stat[ST_BADOP] = 1'b1;
			end else if (pend_err) begin
				// Next op refused until handler clears the flags
				next_s.vec = VEC_FPERR;
				next_s.stat[ST_MF] = 1'b1;
			end else if (align_flt) begin
				next_s.vec = VEC_ALIGN;
				next_s.stat[ST_ALIGN] = 1'b1;
			end else begin
				next_s.flt = 1'b0;
				// Environment load starts with the first byte
				if (issue_d_i.env_load) begin
					next_s.env = ENV_FIRST;
					next_s.env_base = issue_d_i.addr;
					next_s.mem_req = 1'b1;
					next_s.mem_addr = issue_d_i.addr;
				end
			end
			// Pointer saved at the first prefix, not the opcode
			if (next_s.flt) begin
				next_s.sav_ip = issue_d_i.prefix_ip;
				next_s.sav_cs = issue_d_i.cs;
			end
		end

		// Environment load: both end bytes are read before any commit
		unique case (s.env)
			ENV_IDLE: begin
			end
			ENV_FIRST: begin
				if (mem_ack_i) begin
					if (mem_fault_i) begin
						next_s.env = ENV_IDLE;
						next_s.mem_req = 1'b0;
					end else begin
						next_s.env = ENV_LAST;
						next_s.mem_addr = s.env_base + 32'(ENV_LEN - 1);
					end
				end
			end
			ENV_LAST: begin
				if (mem_ack_i) begin
					next_s.mem_req = 1'b0;
					next_s.env = mem_fault_i ? ENV_IDLE : ENV_COMMIT;
				end
			end
			ENV_COMMIT: begin
				// Only now may the internal state change
				next_s.commit = 1'b1;
				next_s.env = ENV_IDLE;
			end
		endcase
		// Segment fault leaves internal state untouched
		if (s.env inside {ENV_FIRST, ENV_LAST} && mem_ack_i && mem_fault_i) begin
			next_s.flt = 1'b1;
			next_s.vec = VEC_SEGAB;
			next_s.stat[ST_SEGAB] = 1'b1;
		end

		// Outcome of a finished instruction
		if (done_i) begin
			next_s.act_v = 1'b1;
			next_s.act = '0;
			next_s.act.sign = done_d_i.sign;
			next_s.act.top_exc = top_exc;
			next_s.act.unmasked = any_unm;
			// Denormal sources normalised when masked
			if (done_d_i.denorm && xmask[ST_DEN]) begin
				next_s.act.normalize = 1'b1;
			end
			// These ops always normalise and never raise invalid
			if (done_d_i.denorm && done_d_i.norm_first) begin
				next_s.act.normalize = 1'b1;
			end
			if (done_d_i.ovf) begin
				if (xmask[ST_OVF]) begin
					// Chop gives the largest finite value of that sign
					if (s.ctrl[CTL_RND +: 2] == RND_CHOP) begin
						next_s.act.sel = SEL_MAXF;
					end else begin
						next_s.act.sel = SEL_INF;
					end
				end else if (done_d_i.stack_dest) begin
					next_s.act.round_en = 1'b1;
					next_s.act.round_prec = done_d_i.prec_by_op ? done_d_i.prec_op
						: s.ctrl[CTL_PREC +: 2];
				end
			end else if (done_d_i.tiny && !xmask[ST_UNF] && done_d_i.stack_dest) begin
				// Exponent first, then the significand
				next_s.act.adj_exp = 1'b1;
				next_s.act.round_en = 1'b1;
				next_s.act.round_prec = done_d_i.prec_gov ? s.ctrl[CTL_PREC +: 2] : PREC_EXT;
			end
			next_s.stat[3:0] = next_s.stat[3:0] | raise;
		end

		// Error pin: at completion, or deferred to the next fp issue
		if (!pend_err && !(done_i && any_unm)) begin
			next_s.err_n = 1'b1;
		end else if (!s.ctrl[CTL_DEFER]) begin
			next_s.err_n = !(pend_err || (done_i && any_unm));
		end else if (issue_i && issue_d_i.is_fp && issue_d_i.defined && pend_err) begin
			next_s.err_n = 1'b0;
		end

		// Issue blocked while loading or while a deferred error waits
		next_s.hold = (next_s.env != ENV_IDLE) || (s.ctrl[CTL_DEFER] && (pend_err
			|| (done_i && any_unm)));

		// Interrupt level from enabled sticky bits
		next_s.irq = |(next_s.stat & s.imask);
	end

	// State register
	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			s <= '0;
			s.ctrl <= CTRL_RST;
			s.sys <= SYS_RST;
			s.stat <= STAT_RST;
			s.err_n <= 1'b1;
			s.env <= ENV_IDLE;
		end else begin
			s <= next_s;
		end
	end

	// Outputs straight from the state register
	assign reg_rdata_o = s.rdata;
	assign mem_req_o = s.mem_req;
	assign mem_addr_o = s.mem_addr;
	assign env_commit_o = s.commit;
	assign fault_o = s.flt;
	assign fault_vec_o = s.vec;
	assign hold_o = s.hold;
	assign act_v_o = s.act_v;
	assign act_o = s.act;
	// Legacy mode: this pin is routed by board logic to an interrupt
	// controller; inside the core the fault path above is used instead
	assign fp_error_out_n = s.err_n;
	assign irq_o = s.irq;

endmodule : fxu_top

// [tb/fxu_chk.sv]
// Port checker of the exception unit: result actions, faults, env load.
// Assumes it is bound onto fxu_top and sees one clock domain only.
`timescale 1ns/1ns
module fxu_chk
	import fxu_pkg::*;
(
	input wire logic       clk_sys_i,      // Unit clock
	input wire logic       nrst_i,         // Sync reset, low
	input wire logic       issue_i,        // Issue pulse
	input wire fxu_issue_t issue_d_i,      // Issued op
	input wire fxu_done_t  done_d_i,       // Outcome
	input wire logic       mem_ack_i,      // Env byte done
	input wire logic       mem_fault_i,    // Env byte faulted
	input wire logic       mem_req_o,      // Env byte wanted
	input wire logic       env_commit_o,   // Env commit
	input wire logic       fault_o,        // Fault pulse
	input wire logic [7:0] fault_vec_o,    // Fault vector
	input wire logic       act_v_o,        // Action valid
	input wire fxu_act_t   act_o,          // Action
	input wire logic       fp_error_out_n  // Error pin
);
	// All checks share the clock; reset silences them
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!nrst_i);

	a_chop_max: assert property (act_v_o && act_o.sel == SEL_MAXF |->
		$past(done_d_i.ovf) && act_o.sign == $past(done_d_i.sign)) else $error("chop result wrong");
	a_ovf_round: assert property (act_v_o && act_o.unmasked && act_o.top_exc == 2'h1
		&& $past(done_d_i.ovf && done_d_i.stack_dest) |-> act_o.round_en) else $error("overflow not rounded");
	a_unf_tiny: assert property (act_v_o && !$past(done_d_i.tiny) |->
		!(act_o.unmasked && act_o.top_exc == 2'h2)) else $error("underflow without tiny");
	a_unf_adjust: assert property (act_v_o && act_o.adj_exp |-> $past(done_d_i.tiny)
		&& ($past(done_d_i.prec_gov || done_d_i.prec_by_op) || act_o.round_prec == PREC_EXT))
		else $error("underflow adjust wrong");
	a_norm_first: assert property (act_v_o && $past(done_d_i.denorm && done_d_i.norm_first)
		|-> act_o.normalize) else $error("denormal not normalised");
	a_err_cause: assert property ($fell(fp_error_out_n) |-> act_v_o || $past(issue_i))
		else $error("error pin fell without cause");
	a_undef_vec: assert property (fault_o && fault_vec_o == VEC_BADOP |->
		$past(issue_i && !issue_d_i.defined)) else $error("bad opcode fault wrong");
	a_undef_nochk: assert property (fault_o && fault_vec_o == VEC_FPERR |->
		$past(issue_d_i.defined)) else $error("error check on undefined op");
	a_align_lvl: assert property (fault_o && fault_vec_o == VEC_ALIGN |-> $past(issue_d_i.cpl == PRIV_USER
		&& issue_d_i.has_mem && !issue_d_i.stack_area)) else $error("alignment fault wrong");
	a_env_order: assert property (env_commit_o |-> $past(!mem_req_o) && $past(mem_req_o, 2))
		else $error("commit out of order");
	a_env_abort: assert property (mem_req_o && mem_ack_i && mem_fault_i |=> !env_commit_o [*3])
		else $error("commit after faulted read");
endmodule : fxu_chk

bind fxu_top fxu_chk u_chk (.clk_sys_i, .nrst_i, .issue_i, .issue_d_i, .done_d_i, .mem_ack_i, .mem_fault_i,
	.mem_req_o, .env_commit_o, .fault_o, .fault_vec_o, .act_v_o, .act_o, .fp_error_out_n);

// [tb/fxu_far_model.sv]
// Far-side model: environment memory and the interrupt controller.
// Assumes the unit's clock.
`timescale 1ns/1ns
module fxu_far_model (
	input  wire logic        clk_sys_i,  // Unit clock
	input  wire logic        req_i,      // Byte read wanted
	input  wire logic [31:0] addr_i,     // Byte address
	input  wire logic [1:0]  lat_i,      // Idle cycles before answer
	input  wire logic        bad_last_i, // Fault the last byte
	input  wire logic        fp_error_out_n_n_i,   // Error pin of the unit
	output logic             ack_o,      // Read done
	output logic             err_o,      // Read faulted
	output logic             maskable_irq_in_o      // Request to the core
);
	logic [1:0]  cnt = 2'h0;     // Cycles waited
	logic        served = 1'b0;  // First byte answered
	logic [31:0] last = 32'h0;   // Address answered last
	logic        flt = 1'b0;     // Fault of current answer

	// Answer each address once
	always @(posedge clk_sys_i) begin
		ack_o <= 1'b0;
		if (!req_i) begin
			cnt <= 2'h0;
			served <= 1'b0;
		end else if (!ack_o && (!served || addr_i != last)) begin
			if (cnt == lat_i) begin
				ack_o <= 1'b1;
				flt <= bad_last_i && served;
				last <= addr_i;
				served <= 1'b1;
				cnt <= 2'h0;
			end else begin
				cnt <= cnt + 2'h1;
			end
		end
	end
	// Qualifier wanders off an answer
	assign err_o = ack_o ? flt : ~flt;
	// Board glue turns the low error level into a request
	assign maskable_irq_in_o = !fp_error_out_n_n_i;
endmodule : fxu_far_model

// [tb/fxu_top_test.sv]
// Self-checking bench of the exception unit.
// Assumes fxu_top, the far-side model and the bound checker.
`timescale 1ns/1ns
module fxu_top_test
	import fxu_pkg::*;
;
	logic        clk_sys_i = 1'b0;
	logic        nrst_i = 1'b0;
	logic [7:0]  reg_addr_i = 8'h00;
	logic [31:0] reg_wdata_i = 32'h0;
	logic        reg_wr_i = 1'b0;
	logic        reg_rd_i = 1'b0;
	logic        issue_i = 1'b0;
	fxu_issue_t  issue_d_i = '0;
	logic        done_i = 1'b0;
	fxu_done_t   done_d_i = '0;
	logic        mem_ack_i, mem_fault_i, mem_req_o, env_commit_o, fault_o, hold_o, act_v_o, fp_error_out_n, irq_o;
	logic [31:0] reg_rdata_o, mem_addr_o;
	logic [31:0] rng = 32'h39;   // Random source state
	logic [7:0]  fault_vec_o, vec, n_fault = 8'h00, n_cmt = 8'h00, f0, c0;
	fxu_act_t    act_o, act;     // Last action seen
	fxu_issue_t  o;
	fxu_done_t   d;
	logic [1:0]  lat = 2'h0;     // Memory latency
	logic        bad = 1'b0, maskable_irq_in; // Fault last byte; glue request
	int          num_errors = 0, check_count = 0;
	logic [22:0] tbl [9] = '{{16'h0F0F, 7'h09}, {16'h020D, 7'h08}, {16'h030F, 7'h04}, {16'h030F, 7'h06},
		{16'h010B, 7'h04}, {16'h030F, 7'h60}, {16'h030C, 7'h68}, {16'h030D, 7'h68}, {16'h030E, 7'h70}};

	always #25 clk_sys_i = ~clk_sys_i;

	fxu_top u_dut (.clk_sys_i, .nrst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
		.issue_i, .issue_d_i, .done_i, .done_d_i, .mem_ack_i, .mem_fault_i, .mem_req_o, .mem_addr_o,
		.env_commit_o, .fault_o, .fault_vec_o, .hold_o, .act_v_o, .act_o, .fp_error_out_n, .irq_o);
	fxu_far_model u_far (.clk_sys_i, .req_i(mem_req_o), .addr_i(mem_addr_o), .lat_i(lat), .bad_last_i(bad),
		.fp_error_out_n_n_i(fp_error_out_n), .ack_o(mem_ack_i), .err_o(mem_fault_i), .maskable_irq_in_o(maskable_irq_in));

	// Catch one-cycle pulses so later checks can see them
	always @(posedge clk_sys_i) begin
		if (fault_o) begin
			n_fault <= n_fault + 8'h01;
			vec <= fault_vec_o;
		end
		if (env_commit_o)
			n_cmt <= n_cmt + 8'h01;
		if (act_v_o)
			act <= act_o;
	end

	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : nxt
	// Flags D,O,U,P that an outcome raises under masks m
	function automatic logic [3:0] flags(input fxu_done_t x, input logic [3:0] m);
		return {x.inexact | (x.ovf & !m[1]), x.tiny & (x.loss | !m[2]), x.ovf, x.denorm & x.arith};
	endfunction : flags
	// Outcome from class bits k; sign and precision source random
	function automatic fxu_done_t dn(input logic [6:0] k, input logic [31:0] r);
		return {k, r[0], 1'b1, r[1], r[4], r[3:2]};
	endfunction : dn
	// Memory op of qword size; k is defined, env load, stack area
	function automatic fxu_issue_t op(input logic [2:0] k, input logic [1:0] cpl, input logic [31:0] a);
		return {1'b1, k, 1'b1, cpl, 2'h2, a, a[15:0] ^ 16'h5A5A, ~a};
	endfunction : op

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_sys_i);
		reg_addr_i <= a;
		reg_wdata_i <= v;
		reg_wr_i <= 1'b1;
		@(posedge clk_sys_i);
		reg_wr_i <= 1'b0;
	endtask : wr
	// Read data stand only in the cycle after the strobe
	task automatic chkr(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_sys_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clk_sys_i);
		reg_rd_i <= 1'b0;
		#1 chk(reg_rdata_o, e);
	endtask : chkr
	task automatic iss(input fxu_issue_t x);
		@(posedge clk_sys_i);
		issue_d_i <= x;
		issue_i <= 1'b1;
		@(posedge clk_sys_i);
		issue_i <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
	endtask : iss
	task automatic fin(input fxu_done_t x);
		@(posedge clk_sys_i);
		done_d_i <= x;
		done_i <= 1'b1;
		@(posedge clk_sys_i);
		done_i <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
	endtask : fin
	// One finished op under control word c, then flags cleared
	task automatic run(input logic [15:0] c, input fxu_done_t x, input logic [8:0] im);
		logic [3:0] f;
		f = flags(x, c[3:0]);
		wr(ADR_CTRL, {16'h0, c});
		wr(ADR_IMASK, {23'h0, im});
		fin(x);
		chkr(ADR_STAT, {28'h0, f});
		chk(fp_error_out_n, !(|(f & ~c[3:0])));
		chk({irq_o, maskable_irq_in}, {|(f & im[3:0]), |(f & ~c[3:0])});
		wr(ADR_STAT, 32'h1FF);
	endtask : run
	task automatic complete_run();
		if (num_errors == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : complete_run

	initial begin
		repeat (20000) @(posedge clk_sys_i);
		num_errors++;
		complete_run();
	end

	initial begin
		repeat (8) @(posedge clk_sys_i);
		nrst_i <= 1'b1;
		for (int i = 0; i < 8; i++)
			chkr(8'(4 * i), i == 0 ? 32'h030F : 32'h0);
		wr(ADR_ACT, 32'hFFF);
		chkr(ADR_ACT, 32'h0);
		// Result handling across masks and rounding
		for (int i = 0; i < 9; i++) begin
			rng = nxt(rng);
			d = dn(tbl[i][6:0], rng);
			run(tbl[i][22:7], d, rng[12:4]);
			case (i)
				0: chk({act.sel, act.sign}, {SEL_MAXF, d.sign});
				1: chk({act.unmasked, act.top_exc, act.round_en, act.round_prec},
					{4'hB, d.prec_by_op ? d.prec_op : 2'h2});
				4: chk({act.adj_exp, act.round_prec}, {1'b1, d.prec_gov ? 2'h1 : PREC_EXT});
				5: chk(act.normalize, 1'b1);
				6: chk(act.top_exc, 2'h0);
				7: chk(act.top_exc, 2'h1);
				8: chk(act.normalize, 1'b1);
				default: chk(act.unmasked, 1'b0);
			endcase
		end
		// Either flag traps every opcode, defined or not
		for (int s = 1; s < 4; s++) begin
			wr(ADR_SYS, 32'(s));
			for (int u = 0; u < 2; u++) begin
				iss(op({u[0], 2'h0}, 2'h0, 32'h0));
				chk(vec, VEC_NODEV);
			end
		end
		chk(n_fault, 8'h06);
		wr(ADR_SYS, 32'h0);
		wr(ADR_CTRL, 32'h030D);
		fin(dn(7'h08, rng));
		iss(op(3'h0, 2'h0, 32'h0));
		chk(vec, VEC_BADOP);
		o = op(3'h4, 2'h0, rng);
		iss(o);
		chk(vec, VEC_FPERR);
		chkr(ADR_SAVIP, o.prefix_ip);
		chkr(ADR_SAVCS, {16'h0, o.cs});
		wr(ADR_STAT, 32'h1FF);
		repeat (2) @(posedge clk_sys_i);
		chk(fp_error_out_n, 1'b1);
		// Alignment: user level only, stack area exempt
		wr(ADR_SYS, 32'h4);
		f0 = n_fault;
		iss(op(3'h4, 2'h3, 32'h4));
		chk(vec, VEC_ALIGN);
		iss(op(3'h4, 2'h0, 32'h4));
		iss(op(3'h5, 2'h3, 32'h4));
		iss(op(3'h4, 2'h3, 32'h8));
		chk(n_fault, f0 + 8'h01);
		wr(ADR_SYS, 32'h0);
		wr(ADR_STAT, 32'h1FF);
		// Environment load, clean then with a faulting last byte
		for (int b = 0; b < 2; b++) begin
			rng = nxt(rng);
			bad = b[0];
			lat = rng[1:0];
			c0 = n_cmt;
			f0 = n_fault;
			iss(op(3'h6, 2'h0, rng));
			for (int i = 0; i < 60 && (hold_o || env_commit_o || fault_o); i++)
				@(posedge clk_sys_i);
			chk(n_cmt, c0 + {7'h0, !b[0]});
			chk(n_fault, f0 + {7'h0, b[0]});
		end
		chk(vec, VEC_SEGAB);
		chkr(ADR_STAT, 32'h80);
		// Deferred reporting waits for the next op
		wr(ADR_STAT, 32'h1FF);
		wr(ADR_CTRL, 32'h130D);
		fin(dn(7'h08, rng));
		chk({fp_error_out_n, hold_o}, 2'h3);
		iss(op(3'h4, 2'h0, 32'h0));
		chk({fp_error_out_n, vec}, {1'b0, VEC_FPERR});
		wr(ADR_STAT, 32'h1FF);
		complete_run();
	end
endmodule : fxu_top_test
